// *** core/r0s_striper.sv ***
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
// How it works
// - Address bit 0 picks the active channel
// - Address steps by one per stripe
// - New command: split, request both (write/read: nonempty share only), steer switch
// - Sixteen 256-bit beats per stripe, one-cycle gap, four-cycle gap on writes with transmit level under 32
// - Reset input synchronous, active low, stable clock
// - Command codes decoded; 101 and 111 reserved
// - Request only while idle, parameters held
// - Busy stays high during operation
// - Sectors for write/read, dwords for SMART/Flush
// - Capacity is two drives' sum, after Identify
// - Sector size select valid after Identify
// - Error flag sticky until reset
// - Channel error vectors passed through unchanged
// - Receive fill count 16 bits, zero-padded
// - Transmit level 16 bits, zero-padded
// - Read data pushed with one-cycle strobe
// - Pop strobe; word returns next cycle
// - Transmit empty flag ignored
// - Byte enables 3:0 are strobe AND mask bit 0
// - Byte enables upper groups copy mask bits 1-3
// - Per-channel 16K 256/128 lane buffers
// - Write stripe needs 512 stored, 1024 lane free
// - Read stripe needs 512 lane stored, 1024 free
module r0s_striper
   import r0s_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sync_reset_n,
   input wire logic [2:0] host_command_code,
   input wire logic [47:0] start_sector,
   input wire logic [47:0] sector_count,
   input wire logic command_request,
   input wire logic [511:0] custom_submission_dwords,
   output logic array_busy,
   output logic [47:0] array_capacity,
   output logic sector_size_select,
   output logic error_flag,
   output logic [31:0] channel_error_vector_0,
   output logic [31:0] channel_error_vector_1,
   input wire logic [15:0] rx_buffer_fill_count,
   output logic rx_buffer_push,
   output logic [255:0] rx_buffer_push_word,
   input wire logic [15:0] tx_buffer_level,
   input wire logic tx_buffer_empty_flag,
   output logic tx_buffer_pop,
   input wire logic [255:0] tx_buffer_pop_word,
   input wire logic ram_write_strobe,
   input wire logic [3:0] dword_write_mask,
   output logic [15:0] result_byte_enable,
   output logic [1:0] ch_cmd_request,
   output logic [2:0] ch_cmd_code,
   output logic [47:0] ch_start_addr_0,
   output logic [47:0] ch_start_addr_1,
   output logic [47:0] ch_length_0,
   output logic [47:0] ch_length_1,
   output logic [511:0] ch_custom_dwords,
   input wire logic [1:0] ch_busy,
   input wire logic [31:0] ch_error_0,
   input wire logic [31:0] ch_error_1,
   input wire logic [47:0] ch_capacity_0,
   input wire logic [47:0] ch_capacity_1,
   input wire logic [1:0] ch_sector_mode,
   input wire logic [1:0] ch_tx_pop,
   output logic [255:0] ch_tx_word,
   output logic [1:0] ch_tx_ready,
   input wire logic [1:0] ch_rx_push,
   input wire logic [255:0] ch_rx_word,
   output logic [1:0] ch_rx_ready,
   input wire logic [1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   r0s_state_t st;
   r0s_state_t next_st;
   logic clr;
   logic [2:0] cmd;
   logic [47:0] cur_addr;
   logic [47:0] remain;
   logic [3:0] beat;
   logic [1:0] wait_cnt;
   logic pop_q;
   logic pop_ch;
   logic hold;
   logic rd_mode;
   logic xfer_ch;
   logic go;
   logic [48:0] a_end;
   logic [48:0] len0;
   logic [48:0] len1;
   logic [10:0] tx_cnt [2];
   logic [10:0] rx_cnt [2];
   logic [255:0] rx_peek [2];

   assign clr = !sync_reset_n;
   assign rd_mode = (cmd == CMD_READ);
   assign xfer_ch = cur_addr[0];

   // Split stripes by address parity
   always_comb begin
      a_end = {1'b0, start_sector} + {1'b0, sector_count};
      len0 = ((a_end + 49'h1) >> 1) - (({1'b0, start_sector} + 49'h1) >> 1);
      len1 = (a_end >> 1) - ({1'b0, start_sector} >> 1);
   end

   // Stripe start checks; empty flag unused
   always_comb begin
      if (rd_mode) begin
         go = (rx_cnt[xfer_ch] >= LANE_RX_FILL_MIN) &&
              ({1'b0, rx_buffer_fill_count} <= RX_USER_DEPTH - RX_USER_ROOM);
      end else begin
         go = (tx_buffer_level >= TX_LVL_STRIPE) &&
              (LANE_HALVES - tx_cnt[xfer_ch] >= LANE_TX_FREE_MIN);
      end
   end

   always_comb begin
      next_st = st;
      case (st)
         R0S_IDLE: begin
            if (command_request) begin
               next_st = R0S_CMD;
            end
         end
         R0S_CMD: begin
            if (ch_cmd_request == 2'b00) begin
               if (cmd == CMD_WRITE || cmd == CMD_READ) begin
                  next_st = R0S_WAIT_DATA;
               end else begin
                  next_st = R0S_WAIT_END;
               end
            end
         end
         R0S_WAIT_DATA: begin
            if (remain == 48'h0) begin
               next_st = R0S_WAIT_END;
            end else if (go && !hold) begin
               next_st = R0S_XFER;
            end
         end
         R0S_XFER: begin
            if (beat == LAST_BEAT) begin
               if (rd_mode || tx_buffer_level >= TX_LVL_TWO) begin
                  next_st = R0S_WAIT_DATA;
               end else begin
                  next_st = R0S_WAIT_FIFO;
               end
            end
         end
         R0S_WAIT_FIFO: begin
            if (wait_cnt == WAIT_FIFO_LAST) begin
               next_st = R0S_WAIT_DATA;
            end
         end
         R0S_WAIT_END: begin
            if (ch_busy == 2'b00) begin
               next_st = R0S_IDLE;
            end
         end
         default: next_st = R0S_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= R0S_IDLE;
      end else if (clr) begin
         st <= R0S_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // Busy until both channels go idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         array_busy <= 1'b0;
      end else if (clr) begin
         array_busy <= 1'b0;
      end else begin
         array_busy <= (next_st != R0S_IDLE);
      end
   end

   // Command capture and requests
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd <= CMD_IDENT;
         ch_cmd_request <= 2'b00;
         ch_cmd_code <= CMD_IDENT;
         ch_start_addr_0 <= 48'h0;
         ch_start_addr_1 <= 48'h0;
         ch_length_0 <= 48'h0;
         ch_length_1 <= 48'h0;
         ch_custom_dwords <= 512'h0;
      end else if (clr) begin
         ch_cmd_request <= 2'b00;
      end else if (st == R0S_IDLE && command_request) begin
         cmd <= host_command_code;
         ch_cmd_code <= host_command_code;
         ch_start_addr_0 <= (start_sector + 48'h1) >> 1;
         ch_start_addr_1 <= start_sector >> 1;
         ch_length_0 <= len0[47:0];
         ch_length_1 <= len1[47:0];
         ch_custom_dwords <= custom_submission_dwords;
         if (host_command_code == CMD_WRITE || host_command_code == CMD_READ) begin
            ch_cmd_request <= {len1 != 49'h0, len0 != 49'h0};
         end else begin
            ch_cmd_request <= 2'b11;
         end
      end else if (st == R0S_CMD) begin
         ch_cmd_request <= ch_cmd_request & ~ch_busy;
      end
   end

   // Stripe counting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur_addr <= 48'h0;
         remain <= 48'h0;
         beat <= 4'h0;
         wait_cnt <= 2'h0;
      end else if (clr) begin
         remain <= 48'h0;
         beat <= 4'h0;
         wait_cnt <= 2'h0;
      end else if (st == R0S_IDLE && command_request) begin
         cur_addr <= start_sector;
         remain <= (host_command_code == CMD_WRITE || host_command_code == CMD_READ) ? sector_count : 48'h0;
         beat <= 4'h0;
      end else begin
         if (st == R0S_XFER) begin
            beat <= beat + 4'h1;
            if (beat == LAST_BEAT) begin
               cur_addr <= cur_addr + 48'h1;
               remain <= remain - 48'h1;
            end
         end
         wait_cnt <= (st == R0S_WAIT_FIFO) ? wait_cnt + 2'h1 : 2'h0;
      end
   end

   // User-side data strobes
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_buffer_pop <= 1'b0;
         pop_q <= 1'b0;
         pop_ch <= 1'b0;
         rx_buffer_push <= 1'b0;
         rx_buffer_push_word <= 256'h0;
      end else if (clr) begin
         tx_buffer_pop <= 1'b0;
         pop_q <= 1'b0;
         rx_buffer_push <= 1'b0;
      end else begin
         tx_buffer_pop <= (next_st == R0S_XFER) && !rd_mode;
         pop_q <= tx_buffer_pop;
         pop_ch <= xfer_ch;
         rx_buffer_push <= (st == R0S_XFER) && rd_mode;
         rx_buffer_push_word <= rx_peek[xfer_ch];
      end
   end

   // Lane buffers, one pair per channel
   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_lane
         logic [127:0] tlo [LANE_WORDS];
         logic [127:0] thi [LANE_WORDS];
         logic [127:0] rlo [LANE_WORDS];
         logic [127:0] rhi [LANE_WORDS];
         logic [8:0] twp;
         logic [9:0] trp;
         logic [9:0] rwp;
         logic [8:0] rrp;
         logic twr;
         logic trd;
         logic rwr;
         logic rrd;
         logic [10:0] next_tx_cnt;
         logic [10:0] next_rx_cnt;

         assign twr = pop_q && (pop_ch == c[0]);
         assign trd = ch_tx_pop[c] && (tx_cnt[c] != 11'h0);
         assign rwr = ch_rx_push[c] && (rx_cnt[c] != LANE_HALVES);
         assign rrd = (st == R0S_XFER) && rd_mode && (xfer_ch == c[0]);
         assign rx_peek[c] = {rhi[rrp], rlo[rrp]};

         always_comb begin
            next_tx_cnt = tx_cnt[c] + (twr ? 11'h2 : 11'h0) - (trd ? 11'h1 : 11'h0);
            next_rx_cnt = rx_cnt[c] + (rwr ? 11'h1 : 11'h0) - (rrd ? 11'h2 : 11'h0);
         end

         always_ff @(posedge clk) begin
            if (twr) begin
               tlo[twp] <= tx_buffer_pop_word[127:0];
               thi[twp] <= tx_buffer_pop_word[255:128];
            end
            if (rwr && !rwp[0]) begin
               rlo[rwp[9:1]] <= ch_rx_word[c*128 +: 128];
            end
            if (rwr && rwp[0]) begin
               rhi[rwp[9:1]] <= ch_rx_word[c*128 +: 128];
            end
         end

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               twp <= 9'h0;
               trp <= 10'h0;
               rwp <= 10'h0;
               rrp <= 9'h0;
               tx_cnt[c] <= 11'h0;
               rx_cnt[c] <= 11'h0;
               ch_tx_ready[c] <= 1'b0;
               ch_rx_ready[c] <= 1'b0;
               ch_tx_word[c*128 +: 128] <= 128'h0;
            end else if (clr) begin
               twp <= 9'h0;
               trp <= 10'h0;
               rwp <= 10'h0;
               rrp <= 9'h0;
               tx_cnt[c] <= 11'h0;
               rx_cnt[c] <= 11'h0;
               ch_tx_ready[c] <= 1'b0;
               ch_rx_ready[c] <= 1'b0;
            end else begin
               twp <= twp + {8'h0, twr};
               trp <= trp + {9'h0, trd};
               rwp <= rwp + {9'h0, rwr};
               rrp <= rrp + {8'h0, rrd};
               tx_cnt[c] <= next_tx_cnt;
               rx_cnt[c] <= next_rx_cnt;
               ch_tx_ready[c] <= (next_tx_cnt != 11'h0);
               ch_rx_ready[c] <= (next_rx_cnt != LANE_HALVES);
               if (trd) begin
                  ch_tx_word[c*128 +: 128] <= trp[0] ? thi[trp[9:1]] : tlo[trp[9:1]];
               end
            end
         end
      end
   endgenerate

   // Identify results, errors
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         array_capacity <= CAPACITY_RESET;
         sector_size_select <= 1'b0;
         error_flag <= 1'b0;
         channel_error_vector_0 <= 32'h0;
         channel_error_vector_1 <= 32'h0;
      end else if (clr) begin
         array_capacity <= CAPACITY_RESET;
         sector_size_select <= 1'b0;
         error_flag <= 1'b0;
         channel_error_vector_0 <= 32'h0;
         channel_error_vector_1 <= 32'h0;
      end else begin
         if (st == R0S_WAIT_END && ch_busy == 2'b00 && cmd == CMD_IDENT) begin
            array_capacity <= ch_capacity_0 + ch_capacity_1;
            sector_size_select <= |ch_sector_mode;
         end
         error_flag <= error_flag | (|ch_error_0) | (|ch_error_1);
         channel_error_vector_0 <= ch_error_0;
         channel_error_vector_1 <= ch_error_1;
      end
   end

   // Result RAM byte enables, registered
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_byte_enable <= 16'h0;
      end else begin
         result_byte_enable[3:0] <= {4{ram_write_strobe & dword_write_mask[0]}};
         result_byte_enable[15:4] <= {{4{dword_write_mask[3]}}, {4{dword_write_mask[2]}},
                                      {4{dword_write_mask[1]}}};
      end
   end

   // Avalon slave: one wait cycle, then answer
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         hold <= CTL_HOLD_RESET;
      end else begin
         avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
         if (avs_write && !avs_waitrequest && avs_address == REG_CONTROL) begin
            hold <= avs_writedata[CTL_HOLD];
         end
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= 32'h0;
            if (avs_address == REG_STATUS) begin
               avs_readdata[ST_BUSY] <= array_busy;
               avs_readdata[ST_ERROR] <= error_flag;
               avs_readdata[ST_MODE] <= sector_size_select;
               avs_readdata[ST_CHAN] <= xfer_ch;
               avs_readdata[ST_STATE +: 3] <= st;
            end else if (avs_address == REG_CONTROL) begin
               avs_readdata[CTL_HOLD] <= hold;
            end
         end
      end
   end

endmodule : r0s_striper

// *** core/r0s_pkg.sv ***
package r0s_pkg;
   // Command codes
   localparam logic [2:0] CMD_IDENT = 3'h0;
   localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_READ = 3'h3;
   localparam logic [2:0] CMD_SMART = 3'h4;
   localparam logic [2:0] CMD_FLUSH = 3'h6;
   // Stripe shape: 16 beats of 256 bits = 512 bytes
   localparam logic [3:0] LAST_BEAT = 4'hf;
   localparam logic [15:0] TX_LVL_STRIPE = 16'h0010;
   localparam logic [15:0] TX_LVL_TWO = 16'h0020;
   localparam logic [16:0] RX_USER_DEPTH = 17'h00400;
   localparam logic [16:0] RX_USER_ROOM = 17'h00020;
   // Lane buffers: 16 Kbyte, counted in 128-bit halves
   localparam int LANE_WORDS = 512;
   localparam logic [10:0] LANE_HALVES = 11'h400;
   localparam logic [10:0] LANE_TX_FREE_MIN = 11'h040;
   localparam logic [10:0] LANE_RX_FILL_MIN = 11'h020;
   localparam logic [1:0] WAIT_FIFO_LAST = 2'h2;
   // Registers
   localparam logic [1:0] REG_STATUS = 2'h0;
   localparam logic [1:0] REG_CONTROL = 2'h1;
   localparam int ST_BUSY = 0;
   localparam int ST_ERROR = 1;
   localparam int ST_MODE = 2;
   localparam int ST_CHAN = 3;
   localparam int ST_STATE = 4;
   localparam int CTL_HOLD = 0;
   localparam logic CTL_HOLD_RESET = 1'b0;
   localparam logic [47:0] CAPACITY_RESET = 48'h0;
   typedef enum logic [2:0] {
      R0S_IDLE = 3'h0,
      R0S_CMD = 3'h1,
      R0S_WAIT_DATA = 3'h3,
      R0S_XFER = 3'h2,
      R0S_WAIT_FIFO = 3'h6,
      R0S_WAIT_END = 3'h7
   } r0s_state_t;
endpackage : r0s_pkg

// *** tb/r0s_striper_props.sv ***
`timescale 1ns/1ps
module r0s_striper_props
   import r0s_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sync_reset_n,
   input wire logic command_request,
   input wire logic [2:0] host_command_code,
   input wire logic array_busy,
   input wire logic error_flag,
   input wire logic [31:0] channel_error_vector_0,
   input wire logic [31:0] channel_error_vector_1,
   input wire logic [31:0] ch_error_0,
   input wire logic [31:0] ch_error_1,
   input wire logic [1:0] ch_busy,
   input wire logic [1:0] ch_cmd_request,
   input wire logic tx_buffer_pop,
   input wire logic rx_buffer_push,
   input wire logic ram_write_strobe,
   input wire logic [3:0] dword_write_mask,
   input wire logic [15:0] result_byte_enable
);
   logic [4:0] pop_run;
   logic [4:0] push_run;
   // Strobe run length
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pop_run <= 5'h0;
         push_run <= 5'h0;
      end else begin
         pop_run <= tx_buffer_pop ? pop_run + 5'h1 : 5'h0;
         push_run <= rx_buffer_push ? push_run + 5'h1 : 5'h0;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst || !sync_reset_n);
   chk_be_low: assert property (result_byte_enable[3:0] == {4{$past(ram_write_strobe & dword_write_mask[0])}})
      else $error("low byte enables wrong");
   chk_be_high: assert property (result_byte_enable[15:4] == {{4{$past(dword_write_mask[3])}},
      {4{$past(dword_write_mask[2])}}, {4{$past(dword_write_mask[1])}}}) else $error("upper byte enables wrong");
   chk_err_copy: assert property ((channel_error_vector_0 == $past(ch_error_0)) &&
      (channel_error_vector_1 == $past(ch_error_1))) else $error("error vectors differ");
   chk_err_set: assert property ((ch_error_0 != 32'h0 || ch_error_1 != 32'h0) |-> ##[1:2] error_flag)
      else $error("error flag not raised");
   chk_err_hold: assert property ($past(error_flag) && $past(sync_reset_n) |-> error_flag)
      else $error("error flag dropped");
   chk_busy_take: assert property (command_request && !array_busy |=> array_busy)
      else $error("request not taken");
   chk_busy_hold: assert property (array_busy && ch_busy != 2'h0 |=> array_busy)
      else $error("busy dropped early");
   chk_ident_both: assert property (command_request && !array_busy && host_command_code == CMD_IDENT |=> ch_cmd_request == 2'h3)
      else $error("identify not sent");
   chk_pop_run: assert property ($fell(tx_buffer_pop) |-> pop_run == 5'h10)
      else $error("pop run not sixteen");
   chk_push_run: assert property ($fell(rx_buffer_push) |-> push_run == 5'h10)
      else $error("push run not sixteen");
endmodule : r0s_striper_props
bind r0s_striper r0s_striper_props r0s_striper_props_inst (.*);

// *** tb/r0s_chan_model.sv ***
`timescale 1ns/1ps
module r0s_chan_model
   import r0s_pkg::*;
#(
   parameter logic [47:0] CAP_0 = 48'h000000010000,
   parameter logic [47:0] CAP_1 = 48'h000000008000
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] ch_cmd_request,
   input wire logic [2:0] ch_cmd_code,
   input wire logic [47:0] ch_length_0,
   input wire logic [47:0] ch_length_1,
   input wire logic [255:0] ch_tx_word,
   input wire logic [1:0] ch_tx_ready,
   input wire logic [1:0] ch_rx_ready,
   output logic [1:0] ch_busy,
   output logic [1:0] ch_tx_pop,
   output logic [1:0] ch_rx_push,
   output logic [255:0] ch_rx_word,
   output logic [47:0] ch_capacity_0,
   output logic [47:0] ch_capacity_1,
   output logic [1:0] ch_sector_mode
);
   logic [15:0] rem [2];
   logic [1:0] gap [2];
   logic [1:0] mode [2];
   logic [6:0] cnt [2];
   logic [1:0] pop_d;
   logic [127:0] got [2][64];
   assign ch_capacity_0 = CAP_0;
   assign ch_capacity_1 = CAP_1;
   assign ch_sector_mode = 2'h0;
   // One half every four cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ch_busy <= 2'h0;
         ch_tx_pop <= 2'h0;
         ch_rx_push <= 2'h0;
         ch_rx_word <= '1;
         pop_d <= 2'h0;
         for (int c = 0; c < 2; c++) begin
            rem[c] <= 16'h0;
            gap[c] <= 2'h0;
            mode[c] <= 2'h0;
            cnt[c] <= 7'h0;
         end
      end else begin
         pop_d <= ch_tx_pop;
         for (int c = 0; c < 2; c++) begin
            ch_tx_pop[c] <= 1'b0;
            ch_rx_push[c] <= 1'b0;
            ch_rx_word[c*128 +: 128] <= ~ch_rx_word[c*128 +: 128];
            if (gap[c] != 2'h0) begin
               gap[c] <= gap[c] - 2'h1;
            end
            if (pop_d[c]) begin
               got[c][cnt[c][5:0]] <= ch_tx_word[c*128 +: 128];
               cnt[c] <= cnt[c] + 7'h1;
            end
            if (ch_cmd_request[c] && !ch_busy[c]) begin
               ch_busy[c] <= 1'b1;
               cnt[c] <= 7'h0;
               mode[c] <= ch_cmd_code == CMD_WRITE ? 2'h1 : ch_cmd_code == CMD_READ ? 2'h2 : 2'h0;
               rem[c] <= (ch_cmd_code == CMD_WRITE || ch_cmd_code == CMD_READ) ?
                         16'((c ? ch_length_1 : ch_length_0) * 48'h20) : 16'h4;
            end else if (ch_busy[c] && rem[c] == 16'h0 && gap[c] == 2'h0 && !ch_tx_pop[c]) begin
               ch_busy[c] <= 1'b0;
            end else if (ch_busy[c] && rem[c] != 16'h0) begin
               if (mode[c] == 2'h0) begin
                  rem[c] <= rem[c] - 16'h1;
               end else if (mode[c] == 2'h1 && ch_tx_ready[c] && gap[c] == 2'h0) begin
                  ch_tx_pop[c] <= 1'b1;
                  rem[c] <= rem[c] - 16'h1;
                  gap[c] <= 2'h3;
               end else if (mode[c] == 2'h2 && ch_rx_ready[c] && gap[c] == 2'h0) begin
                  ch_rx_push[c] <= 1'b1;
                  ch_rx_word[c*128 +: 128] <= 128'(c * 256) + 128'(cnt[c]);
                  cnt[c] <= cnt[c] + 7'h1;
                  rem[c] <= rem[c] - 16'h1;
                  gap[c] <= 2'h3;
               end
            end
         end
      end
   end
endmodule : r0s_chan_model

// *** tb/r0s_striper_tb_top.sv ***
`timescale 1ns/1ps
module r0s_striper_tb_top
   import r0s_pkg::*;
;
   localparam logic [47:0] CAP_0 = 48'h000000012345;
   localparam logic [47:0] CAP_1 = 48'h000000006789;
   logic clk, rst, sync_reset_n, command_request, tx_buffer_empty_flag, ram_write_strobe, avs_read, avs_write;
   logic array_busy, sector_size_select, error_flag, rx_buffer_push, tx_buffer_pop, avs_waitrequest;
   logic [2:0] host_command_code, ch_cmd_code;
   logic [47:0] start_sector, sector_count, array_capacity, ch_start_addr_0, ch_start_addr_1;
   logic [47:0] ch_length_0, ch_length_1, ch_capacity_0, ch_capacity_1;
   logic [511:0] custom_submission_dwords, ch_custom_dwords;
   logic [31:0] channel_error_vector_0, channel_error_vector_1, ch_error_0, ch_error_1, avs_writedata, avs_readdata;
   logic [15:0] rx_buffer_fill_count, tx_buffer_level, result_byte_enable;
   logic [255:0] rx_buffer_push_word, tx_buffer_pop_word, ch_tx_word, ch_rx_word;
   logic [3:0] dword_write_mask;
   logic [1:0] ch_cmd_request, ch_busy, ch_sector_mode, ch_tx_pop, ch_tx_ready, ch_rx_push, ch_rx_ready, avs_address;
   logic [31:0] q;
   logic [255:0] rxq [$];
   int fail_count, check_count, pidx;
   r0s_striper r0s_striper_inst (.*);
   r0s_chan_model #(.CAP_0(CAP_0), .CAP_1(CAP_1)) r0s_chan_model_inst (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function automatic logic [255:0] tx_word(input int w);
      return {96'h0, 32'(2 * w + 1), 96'h0, 32'(2 * w)};
   endfunction : tx_word
   // User transmit FIFO, word one cycle after pop
   always @(posedge clk) begin
      if (tx_buffer_pop === 1'b1) begin
         tx_buffer_pop_word <= tx_word(pidx);
         pidx <= pidx + 1;
         tx_buffer_level <= tx_buffer_level - 16'h1;
      end else begin
         tx_buffer_pop_word <= ~tx_buffer_pop_word;
      end
      if (rx_buffer_push === 1'b1) begin
         rxq.push_back(rx_buffer_push_word);
      end
   end
   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic avs(input logic wr, input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : avs
   task automatic run_cmd(input logic [2:0] code, input logic [47:0] s, input logic [47:0] n);
      @(posedge clk);
      host_command_code <= code;
      start_sector <= s;
      sector_count <= n;
      command_request <= 1'b1;
      do @(posedge clk); while (array_busy !== 1'b1);
      command_request <= 1'b0;
   endtask : run_cmd
   task automatic wait_idle;
      do @(posedge clk); while (array_busy !== 1'b0);
   endtask : wait_idle
   task automatic test_ident;
      check(array_capacity, 48'h0);
      check(sector_size_select, 1'b0);
      run_cmd(CMD_IDENT, 48'h0, 48'h0);
      check(ch_cmd_code, CMD_IDENT);
      wait_idle;
      check(array_capacity, CAP_0 + CAP_1);
      check(sector_size_select, 1'b0);
      $display("identify test done");
   endtask : test_ident
   task automatic test_codes;
      logic [2:0] codes [3];
      codes = '{CMD_SHUTDOWN, CMD_SMART, CMD_FLUSH};
      for (int i = 0; i < 3; i++) begin
         custom_submission_dwords <= {16{32'h5a000000 + 32'(i)}};
         run_cmd(codes[i], 48'h7, 48'h9);
         check(ch_cmd_code, codes[i]);
         check(ch_custom_dwords, {16{32'h5a000000 + 32'(i)}});
         wait_idle;
      end
      $display("command code test done");
   endtask : test_codes
   task automatic test_write;
      run_cmd(CMD_WRITE, 48'h1, 48'h3);
      check(ch_start_addr_0, 48'h1);
      check(ch_length_0, 48'h1);
      check(ch_start_addr_1, 48'h0);
      check(ch_length_1, 48'h2);
      repeat (60) @(posedge clk);
      check(32'(pidx), 32'h0);
      avs(1'b1, REG_CONTROL, 32'h1);
      avs(1'b0, REG_STATUS, 32'h0);
      check(q[ST_BUSY], 1'b1);
      tx_buffer_level <= 16'h0030;
      repeat (60) @(posedge clk);
      check(32'(pidx), 32'h0);
      avs(1'b0, REG_CONTROL, 32'h0);
      check(q[CTL_HOLD], 1'b1);
      avs(1'b0, 2'h2, 32'h0);
      check(q, 32'h0);
      avs(1'b1, REG_CONTROL, 32'h0);
      wait_idle;
      check(32'(pidx), 32'h30);
      for (int k = 0; k < 64; k++) begin
         check(r0s_chan_model_inst.got[1][k], 128'(k < 32 ? k : k + 32));
      end
      for (int k = 0; k < 32; k++) begin
         check(r0s_chan_model_inst.got[0][k], 128'(k + 32));
      end
      $display("write test done");
   endtask : test_write
   task automatic test_read;
      rx_buffer_fill_count <= 16'h0400;
      run_cmd(CMD_READ, 48'h0, 48'h2);
      repeat (120) @(posedge clk);
      check(32'(rxq.size()), 32'h0);
      rx_buffer_fill_count <= 16'h0000;
      wait_idle;
      check(32'(rxq.size()), 32'h20);
      for (int j = 0; j < 32; j++) begin
         check(rxq[j], {128'((j / 16) * 256 + (j % 16) * 2 + 1), 128'((j / 16) * 256 + (j % 16) * 2)});
      end
      $display("read test done");
   endtask : test_read
   task automatic test_bytes;
      for (int v = 0; v < 32; v++) begin
         @(posedge clk);
         ram_write_strobe <= v[4];
         dword_write_mask <= v[3:0];
         repeat (2) @(posedge clk);
         check(result_byte_enable, {{4{v[3]}}, {4{v[2]}}, {4{v[1]}}, {4{v[4] & v[0]}}});
      end
      $display("byte enable test done");
   endtask : test_bytes
   task automatic test_errors;
      @(posedge clk);
      ch_error_1 <= 32'h00000104;
      repeat (3) @(posedge clk);
      check(channel_error_vector_1, 32'h00000104);
      check(channel_error_vector_0, 32'h0);
      check(error_flag, 1'b1);
      ch_error_1 <= 32'h0;
      repeat (3) @(posedge clk);
      check(error_flag, 1'b1);
      sync_reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      sync_reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      check(error_flag, 1'b0);
      check(array_capacity, 48'h0);
      $display("error test done");
   endtask : test_errors
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : give_verdict
   initial begin
      #1500000;
      fail_count++;
      give_verdict;
   end
   initial begin
      {command_request, ram_write_strobe, avs_read, avs_write, sync_reset_n} = '0;
      {rst, tx_buffer_empty_flag} = 2'b11;
      {host_command_code, start_sector, sector_count, custom_submission_dwords} = '0;
      {ch_error_0, ch_error_1, avs_writedata, avs_address, dword_write_mask} = '0;
      {rx_buffer_fill_count, tx_buffer_level, tx_buffer_pop_word} = '0;
      pidx = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      sync_reset_n <= 1'b1;
      test_ident;
      test_codes;
      test_write;
      test_read;
      test_bytes;
      test_errors;
      give_verdict;
   end
endmodule : r0s_striper_tb_top
